// >>> pkg/wkirq_map.svh
// Address map, reset values and reserved-bit patterns of the wakeup block.
// Assumes an 8-bit register port with a 3-bit word address.
//
// Functional notes
// - Edge-select bits 7 and 6 are reserved and always read as 1.
// - Bit 5 picks wakeup pin 5 edge, 0 falling, 1 rising; resets 0.
// - Bits 4..0 pick edges of wakeup pins 4..0, 0 falling; reset 0.
// - Enable bit 7, reset 0, passes direct-transition requests only when 1.
// - Enable bit 6, reset 0, passes clock overflow requests only when 1.
// - Enable bit 5 is one shared enable for all six wakeup pins; reset 0.
// - Enable bit 4 is reserved and always reads as 1.
// - Enable bits 3..0 pass requests of request pins 3..0; reset 0.
// - A clear colliding with a request still lets that request through.
// - Request flag sets on selected edge of an interrupt pin whose function bit (config bits 7..4) is 1; write 0 clears.
// - Direct-transition flag sets on direct sleep while control bit is 1.
`ifndef WKIRQ_MAP_SVH
`define WKIRQ_MAP_SVH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define WKI_ADDR_EDGE   3'h0
`define WKI_ADDR_ENA    3'h1
`define WKI_ADDR_FLAG   3'h2
`define WKI_ADDR_WFLAG  3'h3
`define WKI_ADDR_EXTCFG 3'h4

// ----------------------------------------------------------------
// Reserved bits that read as one, and reset values
// ----------------------------------------------------------------
`define WKI_EDGE_RSV    8'hc0
`define WKI_ENA_RSV     8'h10
`define WKI_FLAG_RSV    8'h30
`define WKI_WAKE_RST    6'h00
`define WKI_EXT_RST     4'h0
`define WKI_READ_IDLE   8'h00
`define WKI_PAD2        2'h0
`define WKI_TRIG_PIN    5

`endif

// >>> pkg/wkirq_pkg.sv
// Types shared by the wakeup edge and enable block.
// Assumes the map header is compiled alongside.
`default_nettype none

package wkirq_pkg;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wkirq_bus_t;

	typedef struct packed {
		logic       dt;
		logic       rtc;
		logic       wake;
		logic [3:0] ext;
	} wkirq_req_t;

	typedef struct packed {
		logic       dt;
		logic       rtc;
		logic       wake;
		logic       rsv;
		logic [3:0] ext;
	} wkirq_ena_t;

	typedef struct packed {
		logic       dt;
		logic       rtc;
		logic [1:0] rsv;
		logic [3:0] ext;
	} wkirq_flag_t;

endpackage

`default_nettype wire

// >>> hw/wkirq_top.sv
// Wakeup edge selection, interrupt enables and request flags.
// Assumes pins and event strobes are synchronous to clk_sys.
//
// The register addresses and the plain strobed port were left to the implementer.
`include "wkirq_map.svh"
`default_nettype none

module wkirq_top
	import wkirq_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire wkirq_bus_t bus,
	output var  logic [7:0] rdata,
	input  wire logic [5:0] wake_pin,
	input  wire logic [3:0] ext_request_pin,
	input  wire logic       rtc_overflow,
	input  wire logic       sleep_direct,
	input  wire logic       direct_transition_control,
	output var  wkirq_req_t req,
	output var  logic       irq,
	output var  logic       converter_trigger_pin
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] edge_hit(
		input logic [5:0] cur,
		input logic [5:0] prev,
		input logic [5:0] pol
	);
		edge_hit = (pol & cur & ~prev) | (~pol & ~cur & prev);
	endfunction

	// Write 0 clears a flag; a new event in the same cycle wins.
	function automatic logic [5:0] flag_next(
		input logic [5:0] flag,
		input logic [5:0] set,
		input logic       hit,
		input logic [5:0] wd
	);
		flag_next = set | (flag & ~({6{hit}} & ~wd));
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [5:0]  edge_sel_ff;
	wkirq_ena_t  ena_ff;
	logic [3:0]  ext_edge_ff;
	logic [3:0]  ext_func_ff;
	wkirq_flag_t flag_ff;
	logic [5:0]  wake_flag_ff;
	logic [5:0]  wake_prev_ff;
	logic [3:0]  ext_prev_ff;
	logic        armed_ff;
	logic [7:0]  rdata_ff;
	wkirq_req_t  req_ff;
	logic        irq_ff;
	logic        trig_ff;

	wkirq_ena_t  wr_ena;
	wkirq_flag_t wr_flag;
	logic        wr_edge;
	logic        wr_en;
	logic        wr_fl;
	logic        wr_wf;
	logic        wr_cfg;
	logic [5:0]  wake_set;
	logic [5:0]  ext_set6;
	logic [5:0]  ext_flag6;
	wkirq_req_t  nxt_req;
	logic [7:0]  nxt_rdata;

	assign wr_ena  = wkirq_ena_t'(bus.wdata);
	assign wr_flag = wkirq_flag_t'(bus.wdata);
	assign wr_edge = bus.wr && bus.addr == `WKI_ADDR_EDGE;
	assign wr_en   = bus.wr && bus.addr == `WKI_ADDR_ENA;
	assign wr_fl   = bus.wr && bus.addr == `WKI_ADDR_FLAG;
	assign wr_wf   = bus.wr && bus.addr == `WKI_ADDR_WFLAG;
	assign wr_cfg  = bus.wr && bus.addr == `WKI_ADDR_EXTCFG;

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	// The first cycle after reset has no valid previous sample, so
	// detection waits one cycle instead of seeing a false edge.
	assign wake_set = armed_ff ?
		edge_hit(wake_pin, wake_prev_ff, edge_sel_ff) :
		`WKI_WAKE_RST;
	assign ext_set6 = armed_ff ?
		edge_hit({`WKI_PAD2, ext_request_pin},
			{`WKI_PAD2, ext_prev_ff},
			{`WKI_PAD2, ext_edge_ff}) &
			{`WKI_PAD2, ext_func_ff} :
		`WKI_WAKE_RST;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			armed_ff     <= 1'b0;
			wake_prev_ff <= `WKI_WAKE_RST;
			ext_prev_ff  <= `WKI_EXT_RST;
		end
		else
		begin
			armed_ff     <= 1'b1;
			wake_prev_ff <= wake_pin;
			ext_prev_ff  <= ext_request_pin;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			edge_sel_ff <= `WKI_WAKE_RST;
		else if (wr_edge)
			edge_sel_ff <= bus.wdata[5:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ena_ff <= wkirq_ena_t'(`WKI_READ_IDLE);
		end
		else if (wr_en)
		begin
			ena_ff     <= wr_ena;
			ena_ff.rsv <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ext_edge_ff <= `WKI_EXT_RST;
			ext_func_ff <= `WKI_EXT_RST;
		end
		else if (wr_cfg)
		begin
			ext_edge_ff <= bus.wdata[3:0];
			ext_func_ff <= bus.wdata[7:4];
		end
	end

	// ----------------------------------------------------------------
	// Request flags
	// ----------------------------------------------------------------
	assign ext_flag6 = flag_next({`WKI_PAD2, flag_ff.ext}, ext_set6,
		wr_fl, {`WKI_PAD2, wr_flag.ext});

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			flag_ff <= wkirq_flag_t'(`WKI_READ_IDLE);
		end
		else
		begin
			flag_ff.dt <= (sleep_direct && direct_transition_control) ||
				(flag_ff.dt && !(wr_fl && !wr_flag.dt));
			flag_ff.rtc <= rtc_overflow ||
				(flag_ff.rtc && !(wr_fl && !wr_flag.rtc));
			flag_ff.rsv <= `WKI_PAD2;
			flag_ff.ext <= ext_flag6[3:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			wake_flag_ff <= `WKI_WAKE_RST;
		else
			wake_flag_ff <= flag_next(wake_flag_ff, wake_set,
				wr_wf, bus.wdata[5:0]);
	end

	// ----------------------------------------------------------------
	// Requests to the CPU
	// ----------------------------------------------------------------
	// Requests are registered, so they trail the flags by one cycle.
	always_comb
	begin
		nxt_req.dt   = flag_ff.dt && ena_ff.dt;
		nxt_req.rtc  = flag_ff.rtc && ena_ff.rtc;
		nxt_req.wake = (|wake_flag_ff) && ena_ff.wake;
		nxt_req.ext  = flag_ff.ext & ena_ff.ext;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			req_ff  <= wkirq_req_t'(`WKI_READ_IDLE);
			irq_ff  <= 1'b0;
			trig_ff <= 1'b0;
		end
		else
		begin
			req_ff  <= nxt_req;
			irq_ff  <= |nxt_req;
			trig_ff <= wake_set[`WKI_TRIG_PIN];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = `WKI_READ_IDLE;
		unique case (bus.addr)
			`WKI_ADDR_EDGE:
				nxt_rdata = `WKI_EDGE_RSV |
					{`WKI_PAD2, edge_sel_ff};
			`WKI_ADDR_ENA:
				nxt_rdata = `WKI_ENA_RSV | 8'(ena_ff);
			`WKI_ADDR_FLAG:
				nxt_rdata = `WKI_FLAG_RSV | 8'(flag_ff);
			`WKI_ADDR_WFLAG:
				nxt_rdata = {`WKI_PAD2, wake_flag_ff};
			`WKI_ADDR_EXTCFG:
				nxt_rdata = {ext_func_ff, ext_edge_ff};
			default:
				nxt_rdata = `WKI_READ_IDLE;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rdata_ff <= `WKI_READ_IDLE;
		else if (bus.rd)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= `WKI_READ_IDLE;
	end

	assign rdata                 = rdata_ff;
	assign req                   = req_ff;
	assign irq                   = irq_ff;
	assign converter_trigger_pin = trig_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_edge_rsv_read: assert property (
		bus.rd && bus.addr == `WKI_ADDR_EDGE |=> rdata[7:6] == 2'h3)
		else $error("Edge register reserved bits not read as one.");

	a_wake5_rise: assert property (
		armed_ff && edge_sel_ff[5] && wake_pin[5] && !wake_prev_ff[5]
		|=> wake_flag_ff[5] && converter_trigger_pin)
		else $error("Rising edge on wakeup pin 5 missed.");

	a_wake0_fall: assert property (
		armed_ff && !edge_sel_ff[0] && $fell(wake_pin[0])
		|=> wake_flag_ff[0])
		else $error("Falling edge on wakeup pin 0 missed.");

	a_dt_gated: assert property (
		!ena_ff.dt && !wr_en |=> ##1 !req.dt)
		else $error("Direct-transition request passed while disabled.");

	a_rtc_gated: assert property (
		rtc_overflow && ena_ff.rtc && !wr_en && !wr_fl |=> ##1 req.rtc)
		else $error("Clock overflow request not presented.");

	a_wake_shared: assert property (
		|wake_flag_ff && ena_ff.wake |=> req.wake && irq)
		else $error("Wakeup request not presented under shared enable.");

	a_ena_rsv_read: assert property (
		bus.rd && bus.addr == `WKI_ADDR_ENA |=> rdata[4])
		else $error("Enable register reserved bit not read as one.");

	a_ext_ena_write: assert property (
		wr_en |=> ena_ff.ext == $past(bus.wdata[3:0]))
		else $error("Request pin enables not written.");

	a_set_wins: assert property (
		ext_set6[0] && wr_fl && !wr_flag.ext[0] |=> flag_ff.ext[0])
		else $error("Request lost against a colliding clear.");

	a_ext_flag_set: assert property (
		ext_func_ff[1] && armed_ff && ext_edge_ff[1] &&
		$rose(ext_request_pin[1]) |=> flag_ff.ext[1])
		else $error("Request pin edge did not set its flag.");

	a_dt_flag_set: assert property (
		sleep_direct && direct_transition_control |=> flag_ff.dt)
		else $error("Direct transition did not set its flag.");

	a_req_pairing: assert property (
		req.ext[2] |-> $past(flag_ff.ext[2] && ena_ff.ext[2]))
		else $error("Request without both flag and enable.");

	c_wake_irq: cover property (wake_set[3] ##1 ena_ff.wake ##1 irq);
	c_clear_race: cover property (ext_set6[0] && wr_fl);
	c_dt_req: cover property (sleep_direct ##[1:4] req.dt);

endmodule

`default_nettype wire

// >>> tb/wkirq_far_model.sv
// Far-side model: wakeup pins, request pins and event strobes.
// Assumes the bench calls its tasks from one process at a time.
`default_nettype none

module wkirq_far_model
(
	input  wire logic       clk_sys,
	output var  logic [5:0] wake_pin,
	output var  logic [3:0] ext_request_pin,
	output var  logic       rtc_overflow,
	output var  logic       sleep_direct,
	output var  logic       dt_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		wake_pin = 6'h00;
		ext_request_pin = 4'h0;
		rtc_overflow = 1'b0;
		sleep_direct = 1'b0;
		dt_ctrl = 1'b0;
	end

	// Pins move once per call, so every change is a clean edge.
	task automatic drive(input logic [5:0] w, input logic [3:0] e);
		@(posedge clk_sys);
		wake_pin <= w;
		ext_request_pin <= e;
	endtask

	task automatic strobe(input logic r, input logic s, input logic c);
		@(posedge clk_sys);
		rtc_overflow <= r;
		sleep_direct <= s;
		dt_ctrl <= c;
		@(posedge clk_sys);
		rtc_overflow <= 1'b0;
		sleep_direct <= 1'b0;
	endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the wakeup edge and enable block.
// Assumes the far-side model drives every pin and event strobe.
`default_nettype none

module testbench
	import wkirq_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0;
	logic       reset = 1'b1;
	wkirq_bus_t bus = '0;
	logic [7:0] rdata;
	logic [5:0] wake_pin;
	logic [3:0] ext_request_pin;
	logic       rtc_overflow, sleep_direct, dtc, irq, trig;
	wkirq_req_t req;
	logic [7:0] m_edge = '0, m_ena = '0, m_flag = '0, m_cfg = '0;
	logic [5:0] m_wflag = '0, pw = '0;
	logic [3:0] pe = '0;
	int         err_count = 0, check_count = 0, m_trig = 0, trig_seen = 0;

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (trig === 1'b1) trig_seen++;

	wkirq_top i_dut (.clk_sys(clk_sys), .reset(reset), .bus(bus),
		.rdata(rdata), .wake_pin(wake_pin),
		.ext_request_pin(ext_request_pin), .rtc_overflow(rtc_overflow),
		.sleep_direct(sleep_direct), .direct_transition_control(dtc),
		.req(req), .irq(irq), .converter_trigger_pin(trig));
	wkirq_far_model i_far (.clk_sys(clk_sys), .wake_pin(wake_pin),
		.ext_request_pin(ext_request_pin), .rtc_overflow(rtc_overflow),
		.sleep_direct(sleep_direct), .dt_ctrl(dtc));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus <= '0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1 v = rdata;
	endtask

	task automatic put(input logic [2:0] a, input logic [7:0] d);
		wr(a, d);
		case (a)
			3'h0: m_edge = d & 8'h3f;
			3'h1: m_ena = d & 8'hef;
			3'h2: m_flag = m_flag & d & 8'hcf;
			3'h3: m_wflag = m_wflag & d[5:0];
			3'h4: m_cfg = d;
			default: ;
		endcase
	endtask

	task automatic edges(input logic [5:0] w, input logic [3:0] e);
		logic [5:0] hw;
		logic [3:0] he;
		hw = (w & ~pw & m_edge[5:0]) | (~w & pw & ~m_edge[5:0]);
		he = (e & ~pe & m_cfg[3:0]) | (~e & pe & ~m_cfg[3:0]);
		m_wflag |= hw;
		m_flag[3:0] |= he & m_cfg[7:4];
		m_trig += hw[5];
		pw = w;
		pe = e;
	endtask

	task automatic pins(input logic [5:0] w, input logic [3:0] e);
		edges(w, e);
		i_far.drive(w, e);
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic check_all;
		logic [7:0] v;
		logic [6:0] r;
		r = {m_flag[7:6] & m_ena[7:6], |m_wflag & m_ena[5],
			m_flag[3:0] & m_ena[3:0]};
		rd(3'h0, v);
		chk(v, m_edge | 8'hc0);
		chk({1'b0, req}, {1'b0, r});
		chk({7'h0, irq}, {7'h0, |r});
		chk(8'(trig_seen), 8'(m_trig));
		rd(3'h1, v);
		chk(v, m_ena | 8'h10);
		rd(3'h2, v);
		chk(v, m_flag | 8'h30);
		rd(3'h3, v);
		chk(v, {2'b00, m_wflag});
		rd(3'h4, v);
		chk(v, m_cfg);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#1000000;
		err_count++;
		report_and_stop();
	end

	initial
	begin
		logic [7:0] v;
		void'($urandom(43));
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		check_all();
		for (int a = 5; a < 8; a++)
		begin
			put(a[2:0], 8'hff);
			rd(a[2:0], v);
			chk(v, 8'h00);
		end
		$display("test reset and map done");
		for (int i = 0; i < 48; i++)
		begin
			if (i % 8 == 0)
			begin
				put(3'h0, 8'($urandom));
				put(3'h1, 8'($urandom));
				put(3'h4, 8'($urandom));
			end
			if (i % 4 == 3)
			begin
				put(3'h2, 8'($urandom));
				put(3'h3, 8'($urandom));
			end
			pins(6'($urandom), 4'($urandom));
			check_all();
		end
		$display("test pin edges done");
		for (int i = 0; i < 8; i++)
		begin
			put(3'h1, {~i[0], i[0], 6'($urandom)});
			i_far.strobe(i[0], i[1], i[2]);
			m_flag[6] |= i[0];
			m_flag[7] |= i[1] & i[2];
			repeat (2) @(posedge clk_sys);
			check_all();
			put(3'h1, 8'h00);
			put(3'h2, 8'($urandom));
		end
		$display("test event strobes done");
		put(3'h4, 8'hff);
		put(3'h1, 8'hff);
		pins(6'h00, 4'h0);
		put(3'h2, 8'h00);
		edges(pw, 4'h1);
		// A clear landing on the same edge as a set must not lose it.
		fork
			i_far.drive(pw, 4'h1);
			wr(3'h2, 8'h00);
		join
		repeat (2) @(posedge clk_sys);
		check_all();
		$display("test clear collision done");
		report_and_stop();
	end
endmodule

`default_nettype wire
